// ==== include/aip_pkg.sv ====
// Purpose: Shared types of the analog input post-processing block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in aip_regs.svh
`default_nettype none
package aip_pkg;
    typedef logic signed [15:0] aip_word_t;
    typedef enum logic {AIP_CYCLIC, AIP_DIRECT} aip_mode_t;
endpackage
`default_nettype wire

// ==== include/aip_regs.svh ====
// Purpose: Register offsets, field positions, limits of the input block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Raw samples are counts with 0 at 0% and 10000 at 100% of range
`ifndef AIP_REGS_SVH
`define AIP_REGS_SVH
`define AIP_CTRL 8'h00
`define AIP_PEAK 8'h04
`define AIP_WBRK 8'h08
`define AIP_UERR 8'h0C
`define AIP_LZ 8'h10
`define AIP_RES_RGN 4'h2
`define AIP_AVG_RGN 4'h3
`define AIP_LOW_RGN 4'h4
`define AIP_HIGH_RGN 4'h5
`define AIP_CTRL_RESTART 0
`define AIP_CTRL_MODE 1
`define AIP_CTRL_USED 4
`define AIP_ERR_SCL 0
`define AIP_ERR_AVE 3
`define AIP_ERR_MODE 5
`define AIP_USED_RST 3'h4
`define AIP_AVG_MAX 16'h0009
`define AIP_RAW_MIN 16'hFE0C
`define AIP_RAW_MAX 16'h2904
`define AIP_FULL 34'sh2710
`define AIP_BRK 16'hF92A
`define AIP_LIM_POS 16'h7D00
`define AIP_LIM_NEG 16'h8300
`define AIP_BRK_VAL 16'h7FFF
`define AIP_SAT_POS 34'sh7FFF
`define AIP_SAT_NEG 34'sh3_FFFF_8000
`endif

// ==== src/aip_avg.sv ====
// Purpose: Moving average of one channel over 2**log2 history entries
// Assumes: log2 changes only together with refill
// Notes: Refill is virtual: unwritten entries read as the fill sample
`include "aip_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module aip_avg (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic refill,
    input wire logic [3:0] log2,
    input wire logic signed [15:0] in_data,
    output logic out_valid,
    output logic signed [15:0] out_data
);
    logic signed [15:0] mem_q [0:511];
    logic signed [15:0] fill_q;
    logic [8:0] idx_q;
    logic [9:0] wr_q;
    logic signed [24:0] sum_q;
    wire [9:0] depth = 10'(10'h001 << log2);
    wire [8:0] mask = 9'(depth - 10'h001);
    wire signed [24:0] in_ext = 25'(in_data);
    // Oldest entry is real only once the ring has wrapped
    wire signed [15:0] oldest = (wr_q >= depth) ? mem_q[idx_q] : fill_q;
    wire signed [24:0] sum_d = refill ? (in_ext <<< log2)
        : sum_q + in_ext - 25'(oldest);
    // Bias negative sums so the shift truncates toward zero
    wire signed [24:0] bias = sum_d[24] ? $signed({16'h0000, mask})
        : 25'sh0000000;
    wire signed [24:0] quot = (sum_d + bias) >>> log2;

    always_ff @(posedge clk)
    begin
        if (in_valid && !refill)
            mem_q[idx_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data <= 16'sh0000;
            fill_q <= 16'sh0000;
            idx_q <= 9'h000;
            wr_q <= 10'h000;
            sum_q <= 25'sh0000000;
        end
        else
        begin
            out_valid <= in_valid;
            if (in_valid)
            begin
                sum_q <= sum_d;
                out_data <= quot[15:0];
                if (refill)
                begin
                    fill_q <= in_data;
                    idx_q <= 9'h000;
                    wr_q <= 10'h000;
                end
                else
                begin
                    idx_q <= (idx_q + 9'h001) & mask;
                    if (wr_q < depth)
                        wr_q <= wr_q + 10'h001;
                end
            end
        end
    end

    a_avg_refill: assert property (@(posedge clk) disable iff (rst)
        in_valid && refill |=> out_data == $past(in_data))
        else $error("refill did not output the first sample");
    a_avg_rate: assert property (@(posedge clk) disable iff (rst)
        in_valid |=> out_valid ##1 (out_valid == $past(in_valid)))
        else $error("average changed the refresh rate");
endmodule
`default_nettype wire

// ==== src/aip_scale.sv ====
// Purpose: Linear or reverse scaling of one channel between two limits
// Assumes: Input in counts, 10000 counts equal full scale
// Notes: Pure combinational; result saturates at the 16-bit ends
`include "aip_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module aip_scale (
    input wire logic signed [15:0] x,
    input wire logic signed [15:0] lo,
    input wire logic signed [15:0] hi,
    output logic signed [15:0] y,
    output logic err
);
    // Signed span makes lo > hi give reverse scaling
    wire signed [16:0] span = 17'(hi) - 17'(lo);
    wire signed [33:0] prod = 34'(x) * 34'(span);
    wire signed [33:0] quo = prod / `AIP_FULL;
    wire signed [33:0] sum = quo + 34'(lo);
    wire lo_bad = lo > $signed(`AIP_LIM_POS) || lo < $signed(`AIP_LIM_NEG);
    wire hi_bad = hi > $signed(`AIP_LIM_POS) || hi < $signed(`AIP_LIM_NEG);
    wire both_zero = lo == 16'sh0000 && hi == 16'sh0000;
    wire on;
    assign err = (lo == hi && !both_zero) || lo_bad || hi_bad;
    assign on = !err && !both_zero;
    // Full lo..hi span times 1.05 can pass 16 bits, so clip
    assign y = !on ? x
        : sum > `AIP_SAT_POS ? 16'sh7FFF
        : sum < `AIP_SAT_NEG ? 16'sh8000
        : sum[15:0];
endmodule
`default_nettype wire

// ==== src/aip_top.sv ====
// Purpose: Four-channel post-processing of analog input conversions
// Assumes: Samples arrive from same-clock logic as raw counts
// Notes: Averaging and scaling settings load only on reset or restart
// Function
// - Each channel result is a signed 16-bit word.
// - Averaging works only in cyclic mode; refresh rate stays unchanged.
// - Depth setting 0 is off, 1 to 9 select 2**n samples.
// - Start and wire-break recovery fill the history with first sample.
// - Newest sample shifts in, oldest drops; output sum over depth.
// - Scaling maps full scale linearly onto low and high limits.
// - Low above high gives reverse scaling.
// - Results extend linearly over -5% to +105% of full scale.
// - Equal or out-of-range limits flag an error and skip scaling.
// - Both limits zero disables scaling without error.
// - While hold bit is 1 output the maximum, averaged if enabled.
// - Break during hold outputs +32767; peak resumes after recovery.
// - Break detection on live-zero ranges below 17.5% under zero.
// - Break flag sets on break, clears on recovery; batch readable.
// - Averaging and scaling settings apply only at reset or restart.
// - Batch break byte holds inputs 1 to 4 in bits 0 to 3.
// - Results of unused inputs always read 0.
// - Scaling error appears at bit 0 of the unit error byte.
`include "aip_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module aip_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic smp_valid,
    input wire logic [1:0] smp_ch,
    input wire logic signed [15:0] smp_data
);
    function automatic logic [3:0] avg_log(input logic [15:0] c);
        return (c > `AIP_AVG_MAX) ? 4'h0 : c[3:0];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic signed [15:0] clamp_raw(
        input logic signed [15:0] v);
        if (v < $signed(`AIP_RAW_MIN))
            return $signed(`AIP_RAW_MIN);
        else if (v > $signed(`AIP_RAW_MAX))
            return $signed(`AIP_RAW_MAX);
        return v;
    endfunction

    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic load_q;
    logic mode_sh_q;
    aip_pkg::aip_mode_t mode_q;
    logic [2:0] used_sh_q;
    logic [2:0] used_q;
    logic [3:0] lz_sh_q;
    logic [3:0] lz_q;
    logic [3:0] hold_q;
    logic ave_err_q;
    logic [15:0] avg_sh_q [4];
    logic [15:0] lo_sh_q [4];
    logic [15:0] hi_sh_q [4];
    logic [3:0] avg_log_q [4];
    aip_pkg::aip_word_t lo_q [4];
    aip_pkg::aip_word_t hi_q [4];
    aip_pkg::aip_word_t res_q [4];
    aip_pkg::aip_word_t pk_q [4];
    logic wb_q [4];
    logic started_q [4];
    logic pk_act_q [4];
    logic [3:0] wb_bits;
    logic [3:0] scl_err;
    logic [3:0] act_bits;
    logic [3:0] avg_bad;
    logic [7:0] uerr;

    // One wait cycle: read data are registered, writes land on release
    wire req = avs_read || avs_write;
    wire wr_en = avs_write && ack_q;
    wire [3:0] rgn = avs_address[7:4];
    wire [1:0] rch = avs_address[3:2];
    wire wr_ctrl = wr_en && avs_address == `AIP_CTRL;
    wire wr_peak = wr_en && avs_address == `AIP_PEAK;
    wire wr_lz = wr_en && avs_address == `AIP_LZ;
    wire wr_avg = wr_en && rgn == `AIP_AVG_RGN;
    wire wr_low = wr_en && rgn == `AIP_LOW_RGN;
    wire wr_high = wr_en && rgn == `AIP_HIGH_RGN;
    wire restart = wr_ctrl && avs_byteenable[0]
        && avs_writedata[`AIP_CTRL_RESTART];
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata = rdata_q;

    always_comb
    begin
        uerr = 8'h00;
        uerr[`AIP_ERR_SCL] = |(scl_err & act_bits);
        uerr[`AIP_ERR_AVE] = ave_err_q;
        uerr[`AIP_ERR_MODE] = mode_q == aip_pkg::AIP_DIRECT;
    end

    always_comb
    begin
        rd_mux = 32'h00000000;
        if (avs_address == `AIP_CTRL)
        begin
            rd_mux[`AIP_CTRL_MODE] = mode_sh_q;
            rd_mux[`AIP_CTRL_USED +: 3] = used_sh_q;
        end
        else if (avs_address == `AIP_PEAK)
            rd_mux[3:0] = hold_q;
        else if (avs_address == `AIP_WBRK)
            rd_mux[3:0] = wb_bits;
        else if (avs_address == `AIP_UERR)
            rd_mux[7:0] = uerr;
        else if (avs_address == `AIP_LZ)
            rd_mux[3:0] = lz_sh_q;
        else if (rgn == `AIP_RES_RGN)
            rd_mux[15:0] = res_q[rch];
        else if (rgn == `AIP_AVG_RGN)
            rd_mux[15:0] = avg_sh_q[rch];
        else if (rgn == `AIP_LOW_RGN)
            rd_mux[15:0] = lo_sh_q[rch];
        else if (rgn == `AIP_HIGH_RGN)
            rd_mux[15:0] = hi_sh_q[rch];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            load_q <= 1'b1;
            mode_sh_q <= 1'b0;
            used_sh_q <= `AIP_USED_RST;
            lz_sh_q <= 4'h0;
            hold_q <= 4'h0;
        end
        else
        begin
            ack_q <= req && !ack_q;
            if (req && !ack_q)
                rdata_q <= rd_mux;
            load_q <= restart;
            if (wr_ctrl && avs_byteenable[0])
            begin
                mode_sh_q <= avs_writedata[`AIP_CTRL_MODE];
                used_sh_q <= avs_writedata[`AIP_CTRL_USED +: 3];
            end
            if (wr_peak && avs_byteenable[0])
                hold_q <= avs_writedata[3:0];
            if (wr_lz && avs_byteenable[0])
                lz_sh_q <= avs_writedata[3:0];
        end
    end

    // Shadow copies take writes; active copies move only on load
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_q <= aip_pkg::AIP_CYCLIC;
            used_q <= 3'h0;
            lz_q <= 4'h0;
            ave_err_q <= 1'b0;
            for (int k = 0; k < 4; k++)
            begin
                avg_sh_q[k] <= 16'h0000;
                lo_sh_q[k] <= 16'h0000;
                hi_sh_q[k] <= 16'h0000;
                avg_log_q[k] <= 4'h0;
                lo_q[k] <= 16'sh0000;
                hi_q[k] <= 16'sh0000;
            end
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (wr_avg && rch == 2'(k))
                    avg_sh_q[k] <= merge16(avg_sh_q[k],
                        avs_writedata[15:0], avs_byteenable[1:0]);
                if (wr_low && rch == 2'(k))
                    lo_sh_q[k] <= merge16(lo_sh_q[k],
                        avs_writedata[15:0], avs_byteenable[1:0]);
                if (wr_high && rch == 2'(k))
                    hi_sh_q[k] <= merge16(hi_sh_q[k],
                        avs_writedata[15:0], avs_byteenable[1:0]);
            end
            if (load_q)
            begin
                mode_q <= aip_pkg::aip_mode_t'(mode_sh_q);
                used_q <= used_sh_q;
                lz_q <= lz_sh_q;
                ave_err_q <= |avg_bad;
                for (int k = 0; k < 4; k++)
                begin
                    avg_log_q[k] <= avg_log(avg_sh_q[k]);
                    lo_q[k] <= $signed(lo_sh_q[k]);
                    hi_q[k] <= $signed(hi_sh_q[k]);
                end
            end
        end
    end

    for (genvar i = 0; i < 4; i++)
    begin : ch_g
        logic av_v;
        aip_pkg::aip_word_t av_d;
        aip_pkg::aip_word_t sc_y;
        wire act = 3'(i) < used_q;
        wire sel = smp_valid && smp_ch == 2'(i) && act && !load_q;
        wire brk = lz_q[i] && smp_data < $signed(`AIP_BRK);
        wire refill = !started_q[i] || wb_q[i];
        wire [3:0] lg = (mode_q == aip_pkg::AIP_DIRECT) ? 4'h0
            : avg_log_q[i];
        wire signed [15:0] x_c = clamp_raw(smp_data);
        wire signed [15:0] pk_max = (sc_y > pk_q[i]) ? sc_y : pk_q[i];
        assign wb_bits[i] = wb_q[i];
        assign act_bits[i] = act;
        assign avg_bad[i] = avg_sh_q[i] > `AIP_AVG_MAX;

        aip_avg u_avg (
            .clk(clk),
            .rst(rst),
            .in_valid(sel && !brk),
            .refill(refill),
            .log2(lg),
            .in_data(x_c),
            .out_valid(av_v),
            .out_data(av_d)
        );

        aip_scale u_scl (
            .x(av_d),
            .lo(lo_q[i]),
            .hi(hi_q[i]),
            .y(sc_y),
            .err(scl_err[i])
        );

        always_ff @(posedge clk)
        begin
            if (rst || load_q)
            begin
                wb_q[i] <= 1'b0;
                started_q[i] <= 1'b0;
                pk_act_q[i] <= 1'b0;
                pk_q[i] <= 16'sh0000;
                res_q[i] <= 16'sh0000;
            end
            else if (!act)
                res_q[i] <= 16'sh0000;
            else
            begin
                if (sel)
                begin
                    wb_q[i] <= brk;
                    started_q[i] <= started_q[i] || !brk;
                end
                if (!hold_q[i])
                    pk_act_q[i] <= 1'b0;
                if (sel && brk)
                    res_q[i] <= $signed(`AIP_BRK_VAL);
                else if (av_v && !wb_q[i])
                begin
                    if (hold_q[i])
                    begin
                        // Peak survives a break: resume from held value
                        pk_act_q[i] <= 1'b1;
                        pk_q[i] <= pk_act_q[i] ? pk_max : sc_y;
                        res_q[i] <= pk_act_q[i] ? pk_max : sc_y;
                    end
                    else
                        res_q[i] <= sc_y;
                end
            end
        end

        a_unused_zero: assert property (@(posedge clk)
            disable iff (rst) !act |=> res_q[i] == 16'sh0000)
            else $error("unused channel result not zero");
        a_break_flag: assert property (@(posedge clk)
            disable iff (rst) sel |=> wb_q[i] == $past(brk))
            else $error("break flag does not follow input");
        a_break_out: assert property (@(posedge clk)
            disable iff (rst) sel && brk |=> res_q[i] == 16'sh7FFF)
            else $error("break result is not full positive");
        a_peak_hold: assert property (@(posedge clk)
            disable iff (rst)
            av_v && hold_q[i] && !wb_q[i] && !(sel && brk) && act && !load_q
            |=> res_q[i] >= $past(sc_y) && res_q[i] == pk_q[i])
            else $error("peak hold lost the maximum");
        a_cfg_stable: assert property (@(posedge clk)
            disable iff (rst) !load_q |=> $stable(avg_log_q[i])
            && $stable(lo_q[i]) && $stable(hi_q[i]))
            else $error("config changed without restart");
        a_direct_noavg: assert property (@(posedge clk)
            disable iff (rst) mode_q == aip_pkg::AIP_DIRECT && sel && !brk
            |=> av_d == $past(x_c))
            else $error("averaging active in direct mode");
        a_scale_off: assert property (@(posedge clk)
            disable iff (rst) lo_q[i] == 16'sh0000 && hi_q[i] == 16'sh0000
            |-> sc_y == av_d && !scl_err[i])
            else $error("zero limits did not disable scaling");
        a_scale_err: assert property (@(posedge clk)
            disable iff (rst) lo_q[i] == hi_q[i] && lo_q[i] != 16'sh0000
            |-> scl_err[i] && sc_y == av_d)
            else $error("equal limits not flagged");
        c_break_seen: cover property (@(posedge clk) disable iff (rst)
            sel && brk ##[1:50] sel && !brk);
        c_peak_held: cover property (@(posedge clk) disable iff (rst)
            av_v && hold_q[i] && pk_act_q[i] && sc_y < pk_q[i]);
    end

    a_bus_wait: assert property (@(posedge clk) disable iff (rst)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held over one cycle");
    c_restart: cover property (@(posedge clk) disable iff (rst)
        restart ##2 used_q != 3'h0);
endmodule
`default_nettype wire

// ==== tb/aip_host_model.sv ====
// Purpose: Controller side bus master for the input block registers
// Assumes: Avalon-MM slave with waitrequest, same clock
// Notes: Tasks are called from the bench; one request at a time
`timescale 1ns/1ps
`default_nettype none
module aip_host_model (
    input wire logic clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end

    // Request held until waitrequest is seen low at a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        avs_write <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the four-channel input post-processing
// Assumes: Raw counts 0..10000 span the range; settings load on restart
// Notes: Expected values are worked out by hand from the scaling rules
`include "aip_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic smp_valid = 1'b0;
    logic [1:0] smp_ch = 2'h0;
    logic signed [15:0] smp_data = 16'h0000;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    aip_top aip_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .smp_valid(smp_valid), .smp_ch(smp_ch), .smp_data(smp_data));

    aip_host_model aip_host_model_inst (.clk(clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Generous ceiling: the whole run needs well under 3000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        aip_host_model_inst.rd(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        aip_host_model_inst.wr(a, {16'h0000, d});
    endtask

    // Restart loads shadow settings; skip the load cycle after it
    task automatic cfg(input logic [2:0] used, input logic mode);
        wr(`AIP_CTRL, {9'h000, used, 2'b00, mode, 1'b1});
        repeat (2) @(posedge clk);
    endtask

    // One sample, then the result word two edges later
    task automatic sr(input logic [1:0] ch, input logic [15:0] d,
                      input logic [15:0] e);
        @(posedge clk);
        smp_valid <= 1'b1;
        smp_ch <= ch;
        smp_data <= d;
        @(posedge clk);
        smp_valid <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk({`AIP_RES_RGN, ch, 2'b00}, {16'h0000, e});
    endtask

    task automatic t_unused;
        cfg(3'h2, 1'b0);
        sr(2'h0, 16'h04D2, 16'h04D2);
        sr(2'h3, 16'h04D2, 16'h0000);
        rdchk(`AIP_UERR, 32'h0000_0000);
        rdchk(8'hFC, 32'h0000_0000);
    endtask

    task automatic t_scale;
        wr({`AIP_LOW_RGN, 4'h0}, 16'hFC18);
        wr({`AIP_HIGH_RGN, 4'h0}, 16'h03E8);
        wr({`AIP_LOW_RGN, 4'h4}, 16'h2710);
        wr({`AIP_HIGH_RGN, 4'h4}, 16'h0000);
        sr(2'h0, 16'h0BB8, 16'h0BB8);
        cfg(3'h4, 1'b0);
        sr(2'h0, 16'h2904, 16'h044C);
        sr(2'h0, 16'hFE0C, 16'hFBB4);
        sr(2'h1, 16'h0000, 16'h2710);
        sr(2'h1, 16'h2904, 16'hFE0C);
        wr({`AIP_LOW_RGN, 4'h8}, 16'h0005);
        wr({`AIP_HIGH_RGN, 4'h8}, 16'h0005);
        cfg(3'h4, 1'b0);
        rdchk(`AIP_UERR, 32'h0000_0001);
        sr(2'h2, 16'h0BB8, 16'h0BB8);
        wr({`AIP_HIGH_RGN, 4'h8}, 16'h7D01);
        cfg(3'h4, 1'b0);
        rdchk(`AIP_UERR, 32'h0000_0001);
        for (int i = 0; i < 3; i++)
        begin
            wr({`AIP_LOW_RGN, i[1:0], 2'b00}, 16'h0000);
            wr({`AIP_HIGH_RGN, i[1:0], 2'b00}, 16'h0000);
        end
        cfg(3'h4, 1'b0);
        rdchk(`AIP_UERR, 32'h0000_0000);
    endtask

    task automatic t_avg;
        logic [15:0] din [5] = '{16'h0064, 16'h00C8, 16'h012C, 16'h0190,
                                 16'h01F4};
        logic [15:0] dex [5] = '{16'h0064, 16'h007D, 16'h00AF, 16'h00FA,
                                 16'h015E};
        wr({`AIP_AVG_RGN, 4'h8}, 16'h0002);
        wr({`AIP_AVG_RGN, 4'hC}, 16'h0001);
        wr({`AIP_AVG_RGN, 4'h4}, 16'h0009);
        cfg(3'h4, 1'b0);
        for (int i = 0; i < 5; i++)
            sr(2'h2, din[i], dex[i]);
        sr(2'h3, 16'hFFFF, 16'hFFFF);
        sr(2'h3, 16'h0000, 16'h0000);
        sr(2'h1, 16'h03E8, 16'h03E8);
        sr(2'h1, 16'h05E8, 16'h03E9);
        cfg(3'h4, 1'b1);
        sr(2'h2, 16'h0064, 16'h0064);
        sr(2'h2, 16'h00C8, 16'h00C8);
        rdchk(`AIP_UERR, 32'h0000_0020);
        wr({`AIP_AVG_RGN, 4'h8}, 16'h000A);
        wr({`AIP_AVG_RGN, 4'hC}, 16'h0000);
        cfg(3'h4, 1'b0);
        rdchk(`AIP_UERR, 32'h0000_0008);
        sr(2'h2, 16'h0064, 16'h0064);
        sr(2'h2, 16'h00C8, 16'h00C8);
        wr({`AIP_AVG_RGN, 4'h8}, 16'h0000);
        cfg(3'h4, 1'b0);
    endtask

    task automatic t_peak;
        wr(`AIP_PEAK, 16'h0001);
        sr(2'h0, 16'h012C, 16'h012C);
        sr(2'h0, 16'h0064, 16'h012C);
        sr(2'h0, 16'h01F4, 16'h01F4);
        sr(2'h0, 16'h00C8, 16'h01F4);
        wr(`AIP_PEAK, 16'h0000);
        sr(2'h0, 16'h0032, 16'h0032);
    endtask

    // Input 2 on a live-zero range with two-entry averaging
    task automatic t_break;
        wr(`AIP_LZ, 16'h0002);
        wr({`AIP_AVG_RGN, 4'h4}, 16'h0001);
        cfg(3'h4, 1'b0);
        sr(2'h0, 16'hF8F8, 16'hFE0C);
        rdchk(`AIP_WBRK, 32'h0000_0000);
        sr(2'h1, 16'h03E8, 16'h03E8);
        sr(2'h1, 16'hF929, 16'h7FFF);
        rdchk(`AIP_WBRK, 32'h0000_0002);
        sr(2'h1, 16'hF92A, 16'hFE0C);
        rdchk(`AIP_WBRK, 32'h0000_0000);
        sr(2'h1, 16'h01F4, 16'h0000);
        wr(`AIP_PEAK, 16'h0002);
        sr(2'h1, 16'h0320, 16'h028A);
        sr(2'h1, 16'hF929, 16'h7FFF);
        sr(2'h1, 16'h0064, 16'h028A);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_unused();
        t_scale();
        t_avg();
        t_peak();
        t_break();
        wrap_up();
    end
endmodule
`default_nettype wire
